// file: cpcs_pkg.sv
package cpcs_pkg;

  // ----------------------------------------------------------------
  // Bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_CLK_CTRL = 4'h0;
  localparam logic [3:0]  OFS_OSC_CTRL = 4'h4;
  localparam logic [3:0]  OFS_STATUS   = 4'h8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Clock control register fields
  // ----------------------------------------------------------------
  localparam int BIT_DIV8      = 0;
  localparam int BIT_DIV_LO    = 1;
  localparam int BIT_DIV_HI    = 2;
  localparam int BIT_WAKE_OVR  = 3;
  localparam int BIT_PSTOP_W   = 4;
  localparam int BIT_LS_OFF    = 5;
  localparam int BIT_XTAL_PIN  = 6;
  localparam int BIT_XTAL_STOP = 7;
  localparam int BIT_SYS_SRC   = 8;
  localparam logic [8:0] CLK_CTRL_RST = 9'h180;

  // ----------------------------------------------------------------
  // Oscillator control register fields
  // ----------------------------------------------------------------
  localparam int BIT_HS_EN     = 0;
  localparam int BIT_OSC_SEL   = 1;
  localparam int BIT_D128_SEL  = 2;
  localparam int BIT_POSTDIV   = 3;
  localparam int BIT_CSPROT    = 6;
  localparam int BIT_LCREAD    = 7;
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Division constants, counted in source edges (two per cycle)
  // ----------------------------------------------------------------
  localparam logic [4:0] RATIO_1  = 5'h01;
  localparam logic [4:0] RATIO_2  = 5'h02;
  localparam logic [4:0] RATIO_4  = 5'h04;
  localparam logic [4:0] RATIO_8  = 5'h08;
  localparam logic [4:0] RATIO_16 = 5'h10;
  localparam logic [3:0] POSTDIV_BASE = 4'h2;
  localparam int         D128_BIT     = 7;
  localparam int         NUM_PCLK     = 5;
  localparam int         NUM_OSC      = 3;

endpackage

// file: cpcs_top.sv
`timescale 1ns/1ps
module cpcs_top (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  // Oscillator levels from outside the clock domain
  input  wire logic                        crystal_clock,
  input  wire logic                        hs_osc_in,
  input  wire logic                        ls_osc_in,
  // Power state from the CPU core
  input  wire logic                        wait_mode,
  input  wire logic                        stop_mode,
  // AXI4-Lite slave
  input  wire logic [cpcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [cpcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Clock outputs
  output logic                             cpu_clk,
  output logic                             watchdog_clk,
  output logic [cpcs_pkg::NUM_PCLK-1:0]    periph_clk,
  output logic                             onchip_osc_clk,
  output logic                             hs_undivided_clk,
  output logic                             hs_divided_clk,
  output logic                             ls_detect_clk,
  output logic                             capture_div128_clk,
  output logic                             crystal_osc_run,
  output logic                             low_current_read_mode
);
  import cpcs_pkg::*;

  // ----------------------------------------------------------------
  // Oscillator synchronisers
  // ----------------------------------------------------------------
  logic [NUM_OSC-1:0] osc_raw;
  logic [NUM_OSC-1:0] s1_q, s2_q, s3_q, lvl_q, edge_q;
  assign osc_raw = {ls_osc_in, hs_osc_in, crystal_clock};

  genvar g;
  generate
    for (g = 0; g < NUM_OSC; g++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          s3_q[g]   <= 1'b0;
          lvl_q[g]  <= 1'b0;
          edge_q[g] <= 1'b0;
        end else if (clk_en) begin
          s1_q[g]   <= osc_raw[g];
          s2_q[g]   <= s1_q[g];
          s3_q[g]   <= s2_q[g];
          // A change counts only once two stages agree
          edge_q[g] <= (s2_q[g] == s3_q[g]) && (s2_q[g] != lvl_q[g]);
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s2_q[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [8:0] clk_ctrl_q;
  logic [7:0] osc_ctrl_q;
  logic       stop_prev_q;
  logic       wait_prev_q;
  logic       pstop_latched_q;
  logic       wr_en;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  logic xtal_ok, ls_on, hs_on, stop_entry;
  assign xtal_ok    = clk_ctrl_q[BIT_XTAL_PIN] && !clk_ctrl_q[BIT_XTAL_STOP];
  assign ls_on      = !clk_ctrl_q[BIT_LS_OFF] && !stop_mode;
  assign hs_on      = osc_ctrl_q[BIT_HS_EN] && !stop_mode;
  assign stop_entry = stop_mode && !stop_prev_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_ctrl_q <= CLK_CTRL_RST;
      osc_ctrl_q <= OSC_CTRL_RST;
    end else if (clk_en) begin
      if (wr_en && wr_addr == OFS_CLK_CTRL) begin
        if (wr_strb[0]) begin
          clk_ctrl_q[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          clk_ctrl_q[8] <= wr_data[8];
        end
      end
      if (wr_en && wr_addr == OFS_OSC_CTRL && wr_strb[0]) begin
        osc_ctrl_q <= wr_data[7:0];
        // Protection, once on, holds until reset
        if (osc_ctrl_q[BIT_CSPROT]) begin
          osc_ctrl_q[BIT_CSPROT] <= 1'b1;
        end
      end
      // Hardware set wins over a software write in the same cycle
      if (stop_entry) begin
        clk_ctrl_q[BIT_DIV8] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stop_prev_q     <= 1'b0;
      wait_prev_q     <= 1'b0;
      pstop_latched_q <= 1'b0;
    end else if (clk_en) begin
      stop_prev_q <= stop_mode;
      wait_prev_q <= wait_mode;
      if (wait_mode && !wait_prev_q) begin
        pstop_latched_q <= clk_ctrl_q[BIT_PSTOP_W];
      end else if (!wait_mode) begin
        pstop_latched_q <= 1'b0;
      end
    end
  end

  assign crystal_osc_run       = !clk_ctrl_q[BIT_XTAL_STOP];
  assign low_current_read_mode = osc_ctrl_q[BIT_LCREAD];

  // ----------------------------------------------------------------
  // High-speed post-divider and on-chip selection
  // ----------------------------------------------------------------
  logic [3:0] hs_cnt_q;
  logic [3:0] hs_half;
  logic       hs_div_q;
  logic       hs_div_edge;
  assign hs_half = osc_ctrl_q[BIT_POSTDIV +: 3] + POSTDIV_BASE;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hs_cnt_q <= 4'h0;
      hs_div_q <= 1'b0;
    end else if (clk_en) begin
      if (!hs_on) begin
        hs_cnt_q <= 4'h0;
        hs_div_q <= 1'b0;
      end else if (edge_q[1]) begin
        if (hs_cnt_q >= hs_half - 4'h1) begin
          hs_cnt_q <= 4'h0;
          hs_div_q <= !hs_div_q;
        end else begin
          hs_cnt_q <= hs_cnt_q + 4'h1;
        end
      end
    end
  end
  assign hs_div_edge = hs_on && edge_q[1] && (hs_cnt_q >= hs_half - 4'h1);

  logic ocl_level, ocl_edge;
  always_comb begin
    if (osc_ctrl_q[BIT_OSC_SEL]) begin
      ocl_level = hs_div_q && hs_on;
      ocl_edge  = hs_div_edge;
    end else begin
      ocl_level = lvl_q[2] && ls_on;
      ocl_edge  = edge_q[2] && ls_on;
    end
  end

  // ----------------------------------------------------------------
  // System clock and glitch-free CPU divider
  // ----------------------------------------------------------------
  logic       src_q;
  logic [4:0] ratio_q, ratio_d, cpu_cnt_q;
  logic       cpu_q, sys_edge, cpu_turn, halt;

  always_comb begin
    if (clk_ctrl_q[BIT_DIV8]) begin
      ratio_d = RATIO_8;
    end else begin
      case ({clk_ctrl_q[BIT_DIV_HI], clk_ctrl_q[BIT_DIV_LO]})
        2'h0:    ratio_d = RATIO_1;
        2'h1:    ratio_d = RATIO_2;
        2'h2:    ratio_d = RATIO_4;
        default: ratio_d = RATIO_16;
      endcase
    end
  end

  // Crystal path when source is zero, on-chip path otherwise
  assign sys_edge = !stop_mode &&
                    (src_q ? ocl_edge : (edge_q[0] && xtal_ok));
  assign cpu_turn = sys_edge && (cpu_cnt_q >= ratio_q - 5'h01);
  assign halt     = wait_mode || stop_mode;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src_q     <= 1'b1;
      ratio_q   <= RATIO_1;
      cpu_cnt_q <= 5'h00;
      cpu_q     <= 1'b0;
    end else if (clk_en) begin
      if (cpu_turn) begin
        cpu_cnt_q <= 5'h00;
        if (cpu_q) begin
          cpu_q <= 1'b0;
          // New ratio and source at the end of a whole period, or in a swap while low
          ratio_q <= ratio_d;
          src_q   <= clk_ctrl_q[BIT_SYS_SRC];
        end else if (!halt) begin
          cpu_q <= 1'b1;
        end
      end else if (sys_edge) begin
        cpu_cnt_q <= cpu_cnt_q + 5'h01;
      end else if (!cpu_q && src_q != clk_ctrl_q[BIT_SYS_SRC]) begin
        // Any cycle without a source edge while low: swap without a short phase
        src_q     <= clk_ctrl_q[BIT_SYS_SRC];
        ratio_q   <= ratio_d;
        cpu_cnt_q <= 5'h00;
      end
    end
  end
  assign cpu_clk = cpu_q;

  // ----------------------------------------------------------------
  // Peripheral clocks
  // ----------------------------------------------------------------
  logic [5:0] pcnt_q;
  logic [NUM_PCLK-1:0] pclk_q;
  localparam int PTAP [NUM_PCLK] = '{0, 1, 2, 3, 5};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pcnt_q <= 6'h00;
    end else if (clk_en && sys_edge && !pstop_latched_q) begin
      pcnt_q <= pcnt_q + 6'h01;
    end
  end

  generate
    for (g = 0; g < NUM_PCLK; g++) begin : g_pclk
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          pclk_q[g] <= 1'b0;
        end else if (clk_en) begin
          pclk_q[g] <= pcnt_q[PTAP[g]];
        end
      end
    end
  endgenerate
  assign periph_clk = pclk_q;

  // ----------------------------------------------------------------
  // Oscillator-derived clocks
  // ----------------------------------------------------------------
  logic [7:0] d128_cnt_q;
  logic       d128_edge;
  logic       ocl_q, hsu_q, hsd_q, lsd_q, d128_q, wdt_q;
  assign d128_edge = osc_ctrl_q[BIT_D128_SEL] ? hs_div_edge
                                              : (edge_q[2] && ls_on);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      d128_cnt_q <= 8'h00;
    end else if (clk_en && d128_edge) begin
      d128_cnt_q <= d128_cnt_q + 8'h01;
    end
  end

  // Wait leaves all of these running; stop or a disabled source oscillator silences them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ocl_q  <= 1'b0;
      hsu_q  <= 1'b0;
      hsd_q  <= 1'b0;
      lsd_q  <= 1'b0;
      d128_q <= 1'b0;
    end else if (clk_en) begin
      ocl_q  <= ocl_level && (ls_on || hs_on);
      hsu_q  <= lvl_q[1] && hs_on;
      hsd_q  <= hs_div_q && hs_on;
      lsd_q  <= lvl_q[2] && ls_on;
      d128_q <= d128_cnt_q[D128_BIT];
    end
  end

  // Protected watchdog clock ignores both stop and the off bit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdt_q <= 1'b0;
    end else if (clk_en) begin
      wdt_q <= osc_ctrl_q[BIT_CSPROT] ? lvl_q[2] : cpu_q;
    end
  end

  assign onchip_osc_clk     = ocl_q;
  assign hs_undivided_clk   = hsu_q;
  assign hs_divided_clk     = hsd_q;
  assign ls_detect_clk      = lsd_q;
  assign capture_div128_clk = d128_q;
  assign watchdog_clk       = wdt_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_q, w_q, bvalid_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign wr_en         = aw_q && w_q && !bvalid_q;
  assign wr_addr       = awaddr_q;
  assign wr_data       = wdata_q;
  assign wr_strb       = wstrb_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bresp_q  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (awaddr_q == OFS_CLK_CTRL || awaddr_q == OFS_OSC_CTRL)
                    ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_CLK_CTRL: rdata_q <= {23'h000000, clk_ctrl_q};
          OFS_OSC_CTRL: rdata_q <= {24'h000000, osc_ctrl_q};
          OFS_STATUS:   rdata_q <= {22'h000000, src_q, ratio_q, cpu_q,
                                    pstop_latched_q, stop_mode, wait_mode};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

// file: cpcs_osc_model.sv
`timescale 1ns/1ps
module cpcs_osc_model #(
  parameter int XT_H = 5,
  parameter int HS_H = 3,
  parameter int LS_H = 4
) (
  input  wire logic clk_sys,
  input  wire logic crystal_osc_run,
  output logic      crystal_clock,
  output logic      hs_osc_in,
  output logic      ls_osc_in
);
  // ----
  // Oscillators
  // ----
  int xt_n;
  int hs_n;
  int ls_n;

  initial begin
    crystal_clock = 1'b0;
    hs_osc_in     = 1'b0;
    ls_osc_in     = 1'b0;
    xt_n          = 0;
    hs_n          = 0;
    ls_n          = 0;
  end

  // Whole-cycle half periods keep every derived period exact
  always @(posedge clk_sys) begin
    hs_n <= (hs_n == HS_H - 1) ? 0 : hs_n + 1;
    ls_n <= (ls_n == LS_H - 1) ? 0 : ls_n + 1;
    if (hs_n == HS_H - 1) begin
      hs_osc_in <= ~hs_osc_in;
    end
    if (ls_n == LS_H - 1) begin
      ls_osc_in <= ~ls_osc_in;
    end
  end

  // Stopped resonator freezes at its last level
  always @(posedge clk_sys) begin
    if (crystal_osc_run) begin
      xt_n <= (xt_n == XT_H - 1) ? 0 : xt_n + 1;
      if (xt_n == XT_H - 1) begin
        crystal_clock <= ~crystal_clock;
      end
    end
  end
endmodule

// file: cpcs_top_properties.sv
`timescale 1ns/1ps
module cpcs_chk (
  input wire logic                        clk_sys,
  input wire logic                        reset,
  input wire logic                        wait_mode,
  input wire logic                        stop_mode,
  input wire logic [cpcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic [cpcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        cpu_clk,
  input wire logic                        watchdog_clk,
  input wire logic [cpcs_pkg::NUM_PCLK-1:0] periph_clk,
  input wire logic                        hs_undivided_clk,
  input wire logic                        hs_divided_clk,
  input wire logic                        crystal_osc_run
);
  import cpcs_pkg::*;
  // ----
  // Shadow of written control bits
  // ----
  logic       wgo;
  logic       hs_en_q;
  logic       prot_q;
  logic       pstop_q;
  logic       frz_q;
  logic [1:0] bexp_q;
  logic [1:0] rexp_q;

  assign wgo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hs_en_q <= 1'b0;
      prot_q  <= 1'b0;
    end else if (wgo && s_axi_awaddr == OFS_OSC_CTRL) begin
      hs_en_q <= s_axi_wdata[BIT_HS_EN];
      prot_q  <= prot_q | s_axi_wdata[BIT_CSPROT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pstop_q <= 1'b0;
    end else if (wgo && s_axi_awaddr == OFS_CLK_CTRL) begin
      pstop_q <= s_axi_wdata[BIT_PSTOP_W];
    end
  end
  // Latched at entry only: a write during wait must not thaw clocks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frz_q <= 1'b0;
    end else begin
      frz_q <= wait_mode && (frz_q || ($rose(wait_mode) && pstop_q));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bexp_q <= RESP_OKAY;
      rexp_q <= RESP_OKAY;
    end else begin
      if (wgo) begin
        bexp_q <= (s_axi_awaddr == OFS_CLK_CTRL ||
                   s_axi_awaddr == OFS_OSC_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rexp_q <= (s_axi_araddr == OFS_CLK_CTRL ||
                   s_axi_araddr == OFS_OSC_CTRL ||
                   s_axi_araddr == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_answer;
    s_axi_bvalid && s_axi_bresp == bexp_q ##1 !s_axi_bvalid;
  endsequence
  sequence r_answer;
    s_axi_rvalid && s_axi_rresp == rexp_q &&
      (rexp_q == RESP_OKAY || s_axi_rdata == 32'h0);
  endsequence

  a_reset_clocks_low: assert property ($fell(reset) |->
    !cpu_clk && periph_clk == '0 && !watchdog_clk)
    else $error("clocks not low after reset");
  a_xtal_run_bit: assert property (
    wgo && s_axi_awaddr == OFS_CLK_CTRL
    |-> ##2 crystal_osc_run == !$past(s_axi_wdata[BIT_XTAL_STOP], 2))
    else $error("crystal run output wrong");
  a_hs_off_still: assert property (!hs_en_q [*4] |->
    $stable(hs_undivided_clk) && $stable(hs_divided_clk))
    else $error("fast clock moves when off");
  a_wait_pclk_frozen: assert property (
    frz_q [*3] |-> $stable(periph_clk))
    else $error("pclk moves in wait");
  a_stop_pclk_still: assert property (stop_mode [*4] |-> $stable(periph_clk))
    else $error("pclk moves in stop");
  a_stop_cpu_low: assert property (stop_mode && $past(stop_mode) &&
    !$past(cpu_clk) |-> !cpu_clk)
    else $error("cpu clock rises in stop");
  a_wait_cpu_low: assert property (wait_mode && $past(wait_mode) &&
    !$past(cpu_clk) |-> !cpu_clk)
    else $error("cpu clock rises in wait");
  a_wdog_prot_runs: assert property (
    prot_q |-> ##[1:16] $changed(watchdog_clk))
    else $error("watchdog clock stalled");
  a_write_answer: assert property (wgo |-> ##2 b_answer)
    else $error("write response wrong");
  a_read_answer: assert property (rd_taken |-> ##[1:2] r_answer)
    else $error("read response wrong");
endmodule

bind cpcs_top cpcs_chk u_cpcs_chk (
  .clk_sys, .reset, .wait_mode, .stop_mode, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .cpu_clk, .watchdog_clk,
  .periph_clk, .hs_undivided_clk, .hs_divided_clk, .crystal_osc_run
);

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpcs_pkg::*;
  localparam int XT_H = 5;
  localparam int HS_H = 3;
  localparam int LS_H = 4;
  logic        clk_sys, reset, clk_en, wait_mode, stop_mode;
  logic        crystal_clock, hs_osc_in, ls_osc_in, crystal_osc_run;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cpu_clk, watchdog_clk;
  logic [4:0]  periph_clk;
  logic        onchip_osc_clk, hs_undivided_clk, hs_divided_clk;
  logic        ls_detect_clk, capture_div128_clk;
  logic [11:0] taps;
  logic [8:0]  cc;
  int          failures, tests_run, seed, p, c, pd;

  assign taps = {capture_div128_clk, ls_detect_clk, hs_divided_clk,
                 hs_undivided_clk, onchip_osc_clk, watchdog_clk, cpu_clk,
                 periph_clk};

  cpcs_top u_cpcs_top (
    .clk_sys, .reset, .clk_en, .crystal_clock, .hs_osc_in, .ls_osc_in,
    .wait_mode, .stop_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_clk, .watchdog_clk, .periph_clk, .onchip_osc_clk, .hs_undivided_clk,
    .hs_divided_clk, .ls_detect_clk, .capture_div128_clk, .crystal_osc_run,
    .low_current_read_mode()
  );

  cpcs_osc_model #(.XT_H(XT_H), .HS_H(HS_H), .LS_H(LS_H)) u_cpcs_osc_model (
    .clk_sys, .crystal_osc_run, .crystal_clock, .hs_osc_in, .ls_osc_in
  );

  always #50 clk_sys = ~clk_sys;

  // ----
  // Checking and bus tasks
  // ----
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Every open-ended wait steps through here, so no loop can hang the run
  task automatic tk(inout int n);
    @(negedge clk_sys);
    n++;
    if (n > 40000) begin
      failures++;
      $display("Wait limit reached at %0t", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    int   n;
    pa = 1'b1;
    pw = 1'b1;
    n  = 0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (pa || pw) begin
      tk(n);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk_sys);
      pa = pa && !ta;
      pw = pw && !tw;
      s_axi_awvalid <= pa;
      s_axi_wvalid  <= pw;
    end
    do tk(n); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do tk(n); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do tk(n); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys);
  endtask

  // Period between the second and third rising edge, old setting flushed
  task automatic per(input int k);
    int   n, e;
    logic v;
    n = 0;
    e = 0;
    p = 0;
    v = taps[k];
    while (e < 3) begin
      tk(n);
      p += (e > 1);
      e += (taps[k] === 1'b1 && v !== 1'b1);
      v = taps[k];
    end
  endtask

  task automatic cnt(input int k);
    logic v;
    repeat (3) @(negedge clk_sys);
    c = 0;
    v = taps[k];
    repeat (40) begin
      @(negedge clk_sys);
      c += (taps[k] !== v);
      v = taps[k];
    end
  endtask

  task automatic mode(input logic w, input logic s);
    @(posedge clk_sys);
    wait_mode <= w;
    stop_mode <= s;
  endtask

  function automatic int cpu_ratio(input logic [8:0] v);
    if (v[BIT_DIV8]) return 8;
    case ({v[BIT_DIV_HI], v[BIT_DIV_LO]})
      2'b00: return 1;
      2'b01: return 2;
      2'b10: return 4;
      default: return 16;
    endcase
  endfunction

  function automatic int pdiv(input int i);
    return (i == 4) ? 32 : (1 << i);
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    {clk_sys, wait_mode, stop_mode, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {reset, clk_en, s_axi_bready, s_axi_rready} = 4'hF;
    s_axi_wstrb = 4'hF;
    failures    = 0;
    tests_run   = 0;
    seed        = 62194;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_CLK_CTRL);
    chk(d, 32'(CLK_CTRL_RST));
    rd(OFS_OSC_CTRL);
    chk(d, 32'(OSC_CTRL_RST));
    chk(32'(crystal_osc_run), 32'h0);
    per(5);
    chk(p, 2 * LS_H);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      cc = (i < 4) ? 9'h100 | 9'(i << 1) : 9'h101 | 9'($random(seed) & 6);
      wr(OFS_CLK_CTRL, 32'(cc));
      per(5);
      chk(p, 2 * cpu_ratio(cc) * LS_H);
      per(6);
      chk(p, 2 * cpu_ratio(cc) * LS_H);
    end
    for (int i = 0; i < 5; i++) begin
      per(i);
      chk(p, 2 * pdiv(i) * LS_H);
    end
    $display("divider test done");
    wr(OFS_CLK_CTRL, 32'h110);
    mode(1'b1, 1'b0);
    cnt(0);
    chk(c, 0);
    per(7);
    chk(p, 2 * LS_H);
    per(10);
    chk(p, 2 * LS_H);
    mode(1'b0, 1'b0);
    wr(OFS_CLK_CTRL, 32'h100);
    mode(1'b1, 1'b0);
    cnt(0);
    chk(32'(c != 0), 32'h1);
    $display("wait test done");
    pd = $random(seed) & 7;
    wr(OFS_OSC_CTRL, 32'((pd << 3) | 3));
    per(9);
    chk(p, 2 * (pd + 2) * HS_H);
    per(8);
    chk(p, 2 * HS_H);
    per(7);
    chk(p, 2 * (pd + 2) * HS_H);
    mode(1'b0, 1'b0);
    per(5);
    chk(p, 2 * (pd + 2) * HS_H);
    per(11);
    chk(p, 256 * LS_H);
    wr(OFS_OSC_CTRL, 32'((pd << 3) | 7));
    per(11);
    chk(p, 256 * (pd + 2) * HS_H);
    $display("fast oscillator test done");
    wr(OFS_CLK_CTRL, 32'h040);
    chk(32'(crystal_osc_run), 32'h1);
    per(5);
    chk(p, 2 * XT_H);
    per(1);
    chk(p, 4 * XT_H);
    per(7);
    chk(p, 2 * (pd + 2) * HS_H);
    wr(OFS_CLK_CTRL, 32'h180);
    chk(32'(crystal_osc_run), 32'h0);
    $display("crystal test done");
    wr(OFS_OSC_CTRL, 32'((pd << 3) | 8'h43));
    mode(1'b0, 1'b1);
    per(6);
    chk(p, 2 * LS_H);
    cnt(0);
    chk(c, 0);
    mode(1'b0, 1'b0);
    rd(OFS_CLK_CTRL);
    chk(32'(d[BIT_DIV8]), 32'h1);
    $display("stop test done");
    wr(OFS_STATUS, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(4'hC, 32'h1FF);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(4'hC);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(OFS_OSC_CTRL);
    chk(d, 32'((pd << 3) | 8'h43));
    $display("bus test done");
    give_verdict();
  end
endmodule
